// [common/mro_pkg.sv]
package mro_pkg;

   // ----------------------------------------
   // Object and service codes
   // ----------------------------------------
   localparam logic [7:0]  ROUTER_CLASS    = 8'h02;
   localparam logic [7:0]  SVC_GET_ALL     = 8'h01;
   localparam logic [7:0]  SVC_GET_SINGLE  = 8'h0E;
   localparam logic [7:0]  REPLY_BIT       = 8'h80;
   localparam logic [7:0]  ATTR_REVISION   = 8'h01;
   localparam logic [7:0]  ATTR_OBJ_LIST   = 8'h01;
   localparam logic [7:0]  ATTR_NUM_AVAIL  = 8'h02;
   localparam logic [7:0]  ATTR_NUM_ACTIVE = 8'h03;
   localparam logic [7:0]  ATTR_ACTIVE_IDS = 8'h04;
   localparam logic [15:0] REVISION_VALUE  = 16'h0001;
   localparam logic [15:0] INSTANCE_ONE    = 16'h0001;

   // ----------------------------------------
   // General status codes of a reply
   // ----------------------------------------
   localparam logic [7:0] ST_SUCCESS       = 8'h00;
   localparam logic [7:0] ST_NO_SERVICE    = 8'h08;
   localparam logic [7:0] ST_NO_ATTRIBUTE  = 8'h14;
   localparam logic [7:0] ST_NO_OBJECT     = 8'h16;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [7:0]  conn;     // Explicit connection the request came on
      logic [7:0]  service;
      logic [7:0]  class_id;
      logic [15:0] inst_id;
      logic [7:0]  attr_id;
   } mro_req_t;

   typedef struct packed {
      logic [7:0] conn;
      logic [7:0] service;
      logic [7:0] status;
   } mro_rsp_hdr_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_HEAD = 4'b0010,
      ST_DATA = 4'b0100,
      ST_FWD  = 4'b1000
   } mro_state_t;

endpackage

// [logic/mro_router.sv]
`timescale 1ns/1ps

// What this block does
// - One entry point reaching every class or instance
// - Class revision attribute reads constant one
// - Object list: count then class codes
// - Attribute 2 returns maximum connection count
// - Attribute 3 returns active connection count
// - Attribute 4 returns active connection IDs
// - Service 0E returns one named attribute
// - Service 01 returns all attributes in order
// - Single read always supported here
// - Class read-all sends revision low first
// - Unsupported attributes keep place with defaults
// - Missing class list gives zero count
// - Unknown target answers object-not-found, router class answered here, other classes forward
// - Reply returns on request's own connection
module mro_router #(
   parameter int N_CLASS = 4,
   parameter int N_CONN  = 4
) (
   // Clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   // Request from explicit messaging
   input  wire logic                         req_valid,
   output logic                              req_ready,
   input  wire mro_pkg::mro_req_t            req,
   // Node configuration
   input  wire logic [N_CLASS-1:0][7:0]      class_list,
   input  wire logic [N_CLASS-1:0]           class_present,
   input  wire logic                         obj_list_en,
   input  wire logic [15:0]                  max_conn,
   input  wire logic [N_CONN-1:0]            conn_active,
   input  wire logic [N_CONN-1:0][15:0]      conn_id,
   // Forward to target object
   output logic                              fwd_valid,
   input  wire logic                         fwd_ready,
   output mro_pkg::mro_req_t                 fwd_req,
   // Reply stream
   output logic                              rsp_valid,
   input  wire logic                         rsp_ready,
   output mro_pkg::mro_rsp_hdr_t             rsp_hdr,
   output logic                              rsp_first,
   output logic                              rsp_last,
   output logic [7:0]                        rsp_data
);

   // ----------------------------------------
   // Reply byte image
   // ----------------------------------------
   localparam int MAX_BYTES = 2 + 2 * N_CLASS + 4 + 2 * N_CONN;
   localparam int CW        = $clog2(MAX_BYTES + 1);

   mro_pkg::mro_state_t state, next_state;
   mro_pkg::mro_req_t   cur, next_cur;
   logic [7:0]          status, next_status;
   logic [CW-1:0]       len, next_len;
   logic [CW-1:0]       idx, next_idx;
   logic [7:0]          img [MAX_BYTES];
   logic [7:0]          next_img [MAX_BYTES];
   mro_pkg::mro_rsp_hdr_t next_hdr;
   logic [7:0]          next_data;

   logic                target_ok;
   logic                is_router;
   logic [15:0]         n_class;
   logic [15:0]         n_active;
   logic [N_CLASS-1:0][15:0] class_ofs;
   logic [N_CONN-1:0][15:0]  conn_ofs;

   // Running counts pack present entries back to back
   always_comb begin
      n_class  = 16'h0000;
      n_active = 16'h0000;
      for (int i = 0; i < N_CLASS; i++) begin
         class_ofs[i] = n_class;
         if (class_present[i] && obj_list_en) begin
            n_class = n_class + 16'h0001;
         end
      end
      for (int j = 0; j < N_CONN; j++) begin
         conn_ofs[j] = n_active;
         if (conn_active[j]) begin
            n_active = n_active + 16'h0001;
         end
      end
   end

   always_comb begin
      is_router = (req.class_id == mro_pkg::ROUTER_CLASS);
      target_ok = 1'b0;
      for (int i = 0; i < N_CLASS; i++) begin
         if (class_present[i] && class_list[i] == req.class_id) begin
            target_ok = 1'b1;
         end
      end
      if (is_router && req.inst_id > mro_pkg::INSTANCE_ONE) begin
         target_ok = 1'b0;
      end
   end

   // ----------------------------------------
   // Request interpreter
   // ----------------------------------------
   always_comb begin
      logic [CW-1:0] p;
      p           = '0;
      next_state  = state;
      next_cur    = cur;
      next_status = status;
      next_len    = len;
      next_idx    = idx;
      for (int k = 0; k < MAX_BYTES; k++) begin
         next_img[k] = img[k];
      end
      case (state)
         mro_pkg::ST_IDLE: begin
            if (req_valid) begin
               next_cur    = req;
               next_idx    = '0;
               next_len    = '0;
               next_status = mro_pkg::ST_SUCCESS;
               // single entry point for every target
               if (!target_ok) begin
                  next_status = mro_pkg::ST_NO_OBJECT;
                  next_state  = mro_pkg::ST_HEAD;
               end else if (!is_router) begin
                  next_state = mro_pkg::ST_FWD;
               end else begin
                  next_state = mro_pkg::ST_HEAD;
                  // single read served whenever any attribute exists
                  if (req.service == mro_pkg::SVC_GET_SINGLE && req.inst_id == '0) begin
                     if (req.attr_id == mro_pkg::ATTR_REVISION) begin
                        next_img[0] = mro_pkg::REVISION_VALUE[7:0];
                        next_img[1] = mro_pkg::REVISION_VALUE[15:8];
                        next_len    = CW'(2);
                     end else begin
                        next_status = mro_pkg::ST_NO_ATTRIBUTE;
                     end
                  end else if (req.service == mro_pkg::SVC_GET_ALL && req.inst_id == '0) begin
                     next_img[0] = mro_pkg::REVISION_VALUE[7:0];
                     next_img[1] = mro_pkg::REVISION_VALUE[15:8];
                     next_len    = CW'(2);
                  end else if (req.service == mro_pkg::SVC_GET_SINGLE ||
                               req.service == mro_pkg::SVC_GET_ALL) begin
                     // fixed instance order, keeps every slot
                     if (req.service == mro_pkg::SVC_GET_ALL || req.attr_id == mro_pkg::ATTR_OBJ_LIST) begin
                        // count then codes; zero count when off
                        next_img[p] = n_class[7:0];
                        next_img[p + CW'(1)] = n_class[15:8];
                        p = p + CW'(2);
                        for (int i = 0; i < N_CLASS; i++) begin
                           if (class_present[i] && obj_list_en) begin
                              next_img[p + CW'(2 * class_ofs[i])] = class_list[i];
                              next_img[p + CW'(2 * class_ofs[i]) + CW'(1)] = 8'h00;
                           end
                        end
                        p = p + CW'(2 * n_class);
                     end
                     if (req.service == mro_pkg::SVC_GET_ALL || req.attr_id == mro_pkg::ATTR_NUM_AVAIL) begin
                        next_img[p] = max_conn[7:0];
                        next_img[p + CW'(1)] = max_conn[15:8];
                        p = p + CW'(2);
                     end
                     if (req.service == mro_pkg::SVC_GET_ALL || req.attr_id == mro_pkg::ATTR_NUM_ACTIVE) begin
                        next_img[p] = n_active[7:0];
                        next_img[p + CW'(1)] = n_active[15:8];
                        p = p + CW'(2);
                     end
                     if (req.service == mro_pkg::SVC_GET_ALL || req.attr_id == mro_pkg::ATTR_ACTIVE_IDS) begin
                        for (int j = 0; j < N_CONN; j++) begin
                           if (conn_active[j]) begin
                              next_img[p + CW'(2 * conn_ofs[j])] = conn_id[j][7:0];
                              next_img[p + CW'(2 * conn_ofs[j]) + CW'(1)] = conn_id[j][15:8];
                           end
                        end
                        p = p + CW'(2 * n_active);
                     end
                     next_len = p;
                     if (req.service == mro_pkg::SVC_GET_SINGLE &&
                         (req.attr_id < mro_pkg::ATTR_OBJ_LIST || req.attr_id > mro_pkg::ATTR_ACTIVE_IDS)) begin
                        next_status = mro_pkg::ST_NO_ATTRIBUTE;
                        next_len    = '0;
                     end
                  end else begin
                     next_status = mro_pkg::ST_NO_SERVICE;
                  end
               end
            end
         end
         mro_pkg::ST_FWD: begin
            if (fwd_ready) begin
               next_state = mro_pkg::ST_IDLE;
            end
         end
         mro_pkg::ST_HEAD: begin
            if (rsp_ready) begin
               next_state = (len == '0) ? mro_pkg::ST_IDLE : mro_pkg::ST_DATA;
            end
         end
         mro_pkg::ST_DATA: begin
            if (rsp_ready) begin
               next_idx = idx + CW'(1);
               if (idx + CW'(1) == len) begin
                  next_state = mro_pkg::ST_IDLE;
               end
            end
         end
         default: next_state = mro_pkg::ST_IDLE;
      endcase
      // reply tagged with the request's connection
      next_hdr  = '{conn: next_cur.conn, service: next_cur.service | mro_pkg::REPLY_BIT, status: next_status};
      // Image is frozen outside idle, so the byte of the next beat is known now
      next_data = (next_state == mro_pkg::ST_DATA) ? img[next_idx] : 8'h00;
   end

   // State registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state  <= mro_pkg::ST_IDLE;
         cur    <= '0;
         status <= 8'h00;
         len    <= '0;
         idx    <= '0;
         rsp_hdr  <= '0;
         rsp_data <= 8'h00;
         for (int k = 0; k < MAX_BYTES; k++) begin
            img[k] <= 8'h00;
         end
      end else begin
         state  <= next_state;
         cur    <= next_cur;
         status <= next_status;
         len    <= next_len;
         idx    <= next_idx;
         rsp_hdr  <= next_hdr;
         rsp_data <= next_data;
         for (int k = 0; k < MAX_BYTES; k++) begin
            img[k] <= next_img[k];
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign req_ready = (state == mro_pkg::ST_IDLE);
   assign fwd_valid = (state == mro_pkg::ST_FWD);
   assign fwd_req   = cur;
   assign rsp_valid = (state == mro_pkg::ST_HEAD) || (state == mro_pkg::ST_DATA);
   assign rsp_first = (state == mro_pkg::ST_HEAD);
   assign rsp_last  = ((state == mro_pkg::ST_HEAD) && len == '0) ||
                      ((state == mro_pkg::ST_DATA) && idx + CW'(1) == len);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_not_found;
      @(posedge clk) disable iff (!rst_n)
      (req_valid && req_ready && !target_ok) |=> rsp_first && rsp_hdr.status == mro_pkg::ST_NO_OBJECT;
   endproperty
   a_not_found: assert property (p_not_found) else $error("unknown target not refused");

   property p_forward;
      @(posedge clk) disable iff (!rst_n)
      (req_valid && req_ready && target_ok && !is_router) |=> fwd_valid && fwd_req == $past(req);
   endproperty
   a_forward: assert property (p_forward) else $error("known target not forwarded");

   property p_conn;
      @(posedge clk) disable iff (!rst_n)
      (req_valid && req_ready && target_ok && is_router) |=> rsp_hdr.conn == $past(req.conn);
   endproperty
   a_conn: assert property (p_conn) else $error("reply on wrong connection");

   sequence s_class_all;
      req_valid && req_ready && is_router && target_ok &&
      req.service == mro_pkg::SVC_GET_ALL && req.inst_id == '0;
   endsequence
   property p_class_all;
      @(posedge clk) disable iff (!rst_n)
      s_class_all |=> len == CW'(2) && img[0] == 8'h01 && img[1] == 8'h00;
   endproperty
   a_class_all: assert property (p_class_all) else $error("class reply bytes wrong");

   property p_len_single;
      @(posedge clk) disable iff (!rst_n)
      (state == mro_pkg::ST_HEAD && cur.inst_id == '0 && cur.service == mro_pkg::SVC_GET_SINGLE
       && status == mro_pkg::ST_SUCCESS) |-> len == CW'(2);
   endproperty
   a_len_single: assert property (p_len_single) else $error("revision length wrong");

   property p_bad_attr;
      @(posedge clk) disable iff (!rst_n)
      (req_valid && req_ready && is_router && target_ok && req.service == mro_pkg::SVC_GET_SINGLE
       && req.attr_id > mro_pkg::ATTR_ACTIVE_IDS) |=> status == mro_pkg::ST_NO_ATTRIBUTE && len == '0;
   endproperty
   a_bad_attr: assert property (p_bad_attr) else $error("reserved attribute answered");

   property p_count;
      @(posedge clk) disable iff (!rst_n)
      (req_valid && req_ready && is_router && target_ok && req.inst_id != '0 &&
       req.service == mro_pkg::SVC_GET_SINGLE && req.attr_id == mro_pkg::ATTR_NUM_ACTIVE)
      |=> img[0] == $past(n_active[7:0]) && len == CW'(2);
   endproperty
   a_count: assert property (p_count) else $error("active count wrong");

   property p_all_len;
      @(posedge clk) disable iff (!rst_n)
      (req_valid && req_ready && is_router && target_ok && req.inst_id != '0 &&
       req.service == mro_pkg::SVC_GET_ALL) |=> len == $past(CW'(6 + 2 * n_class + 2 * n_active));
   endproperty
   a_all_len: assert property (p_all_len) else $error("read-all length wrong");

endmodule

// [verif/mro_client.sv]
`timescale 1ns/1ps

// ----------------------------------------
// Far-side client: sinks replies, accepts forwards
// ----------------------------------------
module mro_client (
   // Clock and pace
   input  wire logic clk,
   input  wire logic slow,
   // Handshakes back to the router
   output logic      rsp_ready,
   output logic      fwd_ready
);
   // Prompt when fast, random stalls when slow
   initial begin
      rsp_ready = 1'b0;
      fwd_ready = 1'b0;
      forever begin
         @(negedge clk);
         rsp_ready = !slow || ($urandom_range(0, 2) == 0);
         fwd_ready = !slow || ($urandom_range(0, 3) == 0);
      end
   end
endmodule

// [verif/mro_router_test.sv]
`timescale 1ns/1ps

module mro_router_test;

   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic                  clk           = 1'b0;
   logic                  rst_n         = 1'b0;
   logic                  req_valid     = 1'b0;
   logic                  req_ready;
   mro_pkg::mro_req_t     req           = '0;
   logic [3:0][7:0]       class_list    = {8'h05, 8'h03, 8'h01, 8'h02};
   logic [3:0]            class_present = 4'hF;
   logic                  obj_list_en   = 1'b1;
   logic [15:0]           max_conn      = 16'h0000;
   logic [3:0]            conn_active   = 4'h1;
   logic [3:0][15:0]      conn_id       = '0;
   logic                  fwd_valid;
   logic                  fwd_ready;
   logic                  rsp_valid;
   logic                  rsp_ready;
   logic                  rsp_first;
   logic                  rsp_last;
   logic [7:0]            rsp_data;
   mro_pkg::mro_req_t     fwd_req;
   mro_pkg::mro_rsp_hdr_t rsp_hdr;
   logic                  slow          = 1'b0;
   int                    failures      = 0;
   int                    n_compared    = 0;
   logic [7:0]            svcs[3]       = '{8'h01, 8'h0E, 8'h4B};
   logic [7:0]            clss[5]       = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h2B};

   // 40 MHz clock
   always #12.5 clk = ~clk;

   // Design and far side
   mro_router #(.N_CLASS(4), .N_CONN(4)) dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .class_list(class_list), .class_present(class_present),
      .obj_list_en(obj_list_en), .max_conn(max_conn), .conn_active(conn_active), .conn_id(conn_id),
      .fwd_valid(fwd_valid), .fwd_ready(fwd_ready), .fwd_req(fwd_req), .rsp_valid(rsp_valid),
      .rsp_ready(rsp_ready), .rsp_hdr(rsp_hdr), .rsp_first(rsp_first), .rsp_last(rsp_last),
      .rsp_data(rsp_data));
   mro_client client (.clk(clk), .slow(slow), .rsp_ready(rsp_ready), .fwd_ready(fwd_ready));

   // ----------------------------------------
   // Compare and verdict
   // ----------------------------------------
   task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_req(input mro_pkg::mro_req_t exp, input mro_pkg::mro_req_t got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("wrong value fwd_req expected %h seen %h", exp, got);
      end
   endtask

   task automatic give_verdict();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // Expected reply image
   // ----------------------------------------
   function automatic void push16(ref logic [7:0] q[$], input logic [15:0] v);
      q.push_back(v[7:0]);
      q.push_back(v[15:8]);
   endfunction

   task automatic expect_of(input mro_pkg::mro_req_t r, output bit fwd, output logic [7:0] st,
                            ref logic [7:0] q[$]);
      bit          known;
      bit          all;
      logic [15:0] n_cls;
      logic [15:0] n_act;
      q.delete();
      fwd = 0;
      st = mro_pkg::ST_SUCCESS;
      known = 0;
      n_cls = 0;
      n_act = 0;
      all = (r.service == mro_pkg::SVC_GET_ALL);
      for (int i = 0; i < 4; i++) begin
         if (class_present[i] && class_list[i] == r.class_id) known = 1;
         if (class_present[i] && obj_list_en) n_cls++;
         if (conn_active[i]) n_act++;
      end
      if (!known) st = mro_pkg::ST_NO_OBJECT;
      else if (r.class_id != mro_pkg::ROUTER_CLASS) fwd = 1;
      else if (r.inst_id > mro_pkg::INSTANCE_ONE) st = mro_pkg::ST_NO_OBJECT;
      else if (!all && r.service != mro_pkg::SVC_GET_SINGLE) st = mro_pkg::ST_NO_SERVICE;
      else if (r.inst_id == 16'h0000 && (all || r.attr_id == 8'h01)) push16(q, mro_pkg::REVISION_VALUE);
      else if (r.inst_id == 16'h0000) st = mro_pkg::ST_NO_ATTRIBUTE;
      else begin
         if (all || r.attr_id == 8'h01) begin
            push16(q, n_cls);
            for (int i = 0; i < 4; i++) if (class_present[i] && obj_list_en) push16(q, {8'h00, class_list[i]});
         end
         if (all || r.attr_id == 8'h02) push16(q, max_conn);
         if (all || r.attr_id == 8'h03) push16(q, n_act);
         if (all || r.attr_id == 8'h04) for (int i = 0; i < 4; i++) if (conn_active[i]) push16(q, conn_id[i]);
         if (!all && (r.attr_id == 8'h00 || r.attr_id > 8'h04)) st = mro_pkg::ST_NO_ATTRIBUTE;
      end
   endtask

   // ----------------------------------------
   // One request and its whole answer
   // ----------------------------------------
   task automatic do_req(input mro_pkg::mro_req_t r);
      bit         fwd;
      bit         done;
      logic [7:0] st;
      logic [7:0] q[$];
      int         k;
      int         n;
      @(negedge clk);
      expect_of(r, fwd, st, q);
      req = r;
      req_valid = 1'b1;
      @(posedge clk);
      cmp_byte("req_ready", 8'h01, {7'h0, req_ready});
      @(negedge clk);
      req_valid = 1'b0;
      req = ~r;
      k = 0;
      n = 0;
      done = 0;
      while (!done && n < 2000) begin
         @(posedge clk);
         n++;
         if (fwd_valid === 1'b1 && fwd_ready === 1'b1) begin
            cmp_byte("forwarded", {7'h0, fwd}, 8'h01);
            cmp_req(r, fwd_req);
            done = 1;
         end else if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
            if (k == 0) begin
               cmp_byte("forwarded", {7'h0, fwd}, 8'h00);
               cmp_byte("status", st, rsp_hdr.status);
               cmp_byte("conn", r.conn, rsp_hdr.conn);
               cmp_byte("service", r.service | mro_pkg::REPLY_BIT, rsp_hdr.service);
            end else
               cmp_byte("data", q[k-1], rsp_data);
            cmp_byte("first", {7'h0, k == 0}, {7'h0, rsp_first});
            cmp_byte("last", {7'h0, k == q.size()}, {7'h0, rsp_last});
            done = (rsp_last === 1'b1);
            k++;
         end
      end
      if (!done) cmp_byte("done", 8'h01, 8'h00);
   endtask

   // Watchdog against a hang
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      give_verdict();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      mro_pkg::mro_req_t r;
      void'($urandom(7517));
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      max_conn = 16'h1234;
      conn_active = 4'hA;
      conn_id = {16'hD00D, 16'hC0DE, 16'hBEEF, 16'hA55A};
      do_req({8'h21, 8'h0E, 8'h02, 16'h0000, 8'h01});
      do_req({8'h22, 8'h01, 8'h02, 16'h0000, 8'h00});
      do_req({8'h23, 8'h0E, 8'h02, 16'h0000, 8'h02});
      do_req({8'h24, 8'h0E, 8'h02, 16'h0001, 8'h00});
      do_req({8'h25, 8'h0E, 8'h02, 16'h0001, 8'h05});
      do_req({8'h26, 8'h4B, 8'h02, 16'h0001, 8'h01});
      do_req({8'h27, 8'h0E, 8'h02, 16'h0002, 8'h01});
      do_req({8'h28, 8'h0E, 8'h2B, 16'h0001, 8'h01});
      do_req({8'h29, 8'h0E, 8'h03, 16'h0001, 8'h01});
      for (int a = 1; a <= 4; a++) do_req({8'h30, 8'h0E, 8'h02, 16'h0001, 8'(a)});
      do_req({8'h31, 8'h01, 8'h02, 16'h0001, 8'h00});
      @(negedge clk);
      obj_list_en = 1'b0;
      do_req({8'h32, 8'h01, 8'h02, 16'h0001, 8'h00});
      for (int t = 0; t < 300; t++) begin
         r.conn = 8'($urandom);
         r.service = svcs[$urandom_range(0, 2)];
         r.class_id = clss[$urandom_range(0, 4)];
         r.inst_id = 16'($urandom_range(0, 2));
         r.attr_id = 8'($urandom_range(0, 5));
         @(negedge clk);
         slow = 1'($urandom);
         class_present = 4'($urandom) | 4'h1;
         conn_active = 4'($urandom) | 4'h1;
         conn_id = {$urandom, $urandom};
         max_conn = 16'($urandom);
         obj_list_en = (r.service == mro_pkg::SVC_GET_ALL) ? 1'($urandom) : 1'b1;
         do_req(r);
      end
      give_verdict();
   end
endmodule
